// [rtl/hpc_pkg.sv]
// Shared constants and carrier types of the host port control and status registers
package hpc_pkg;

	// ----------------------------------------------------------------
	// Register addresses on the byte-wide host port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int BYTE_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_CFG_DATA = 5'h04;

	// ----------------------------------------------------------------
	// Control register two fields
	// ----------------------------------------------------------------
	localparam int CTRL_FIELD_W = 6;
	localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_DATA_READY_BIT = 1;
	localparam int STAT_IRQ_PEND_BIT = 2;
	localparam int STAT_ERR_LSB = 3;
	localparam int STAT_ERR_MSB = 4;
	localparam int STAT_INIT_BIT = 6;
	localparam int STAT_DONE_BIT = 7;

	// ----------------------------------------------------------------
	// Bit stream error codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_ID = 2'h1;
	localparam logic [1:0] ERR_CHECKSUM = 2'h2;
	localparam logic [1:0] ERR_STOP_ALIGN = 2'h3;

	// ----------------------------------------------------------------
	// Serializer and buffer sizing
	// ----------------------------------------------------------------
	localparam int SER_CNT_W = 4;
	localparam logic [SER_CNT_W-1:0] SER_BITS = 4'h8;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// Control register two, bit 5 down to bit 0
	typedef struct packed {
		logic user_mode_enable;
		logic bus_hold_enable;
		logic chain_output_enable;
		logic user_irq_enable;
		logic stream_error_irq_enable;
		logic cfg_data_irq_enable;
	} hpc_ctrl_t;

	// One host request, valid for one cycle
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
	} hpc_host_req_t;

	// Configuration side status inputs
	typedef struct packed {
		logic cfg_mode;
		logic readback_mode;
		logic cfg_byte_req;
		logic rb_byte_avail;
		logic stream_error_valid;
		logic [1:0] stream_error_code;
	} hpc_cfg_status_t;

	// Host write sequencer states
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_PUSH,
		WR_HOLD
	} hpc_wr_state_t;

	// All state of the main module
	typedef struct packed {
		hpc_ctrl_t ctrl;
		hpc_wr_state_t wr_state;
		logic [BYTE_W-1:0] wr_byte;
		logic [BYTE_W-1:0] rdata;
		logic ack;
		logic data_ready;
		logic irq_pending;
		logic [1:0] err_flags;
		logic int_n;
		logic prev_cfg_req;
		logic prev_rb_req;
		logic prev_done;
		logic user_mode_active;
		logic [BYTE_W-1:0] ser_shift;
		logic [SER_CNT_W-1:0] ser_cnt;
		logic ser_out;
		logic ser_valid;
	} hpc_state_t;

endpackage : hpc_pkg

// [rtl/hpc_pair_buffer.sv]
// Two-entry valid/ready buffer between host writes and the chain serializer
`timescale 1ns/10ps

module hpc_pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	// ----------------------------------------------------------------
	// Sizing and elaboration check
	// ----------------------------------------------------------------
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	generate
		if (WIDTH < 1 || DEPTH != 2) begin : g_bad_size
			$error("hpc_pair_buffer serves WIDTH >= 1 and DEPTH = 2 only");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W-1:0] wr_ptr;
		logic [CNT_W-1:0] count;
	} hpc_buf_state_t;

	hpc_buf_state_t st; // Registered state
	hpc_buf_state_t next_st; // Next state
	logic push; // Word taken this cycle
	logic pop; // Word handed on this cycle

	// Honest flags straight from the count
	assign in_ready = (st.count != CNT_W'(DEPTH));
	assign out_valid = (st.count != '0);
	assign out_data = st.mem[st.rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer and count update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr = st.wr_ptr + PTR_W'(1);
		end
		if (pop) begin
			next_st.rd_ptr = st.rd_ptr + PTR_W'(1);
		end
		// Simultaneous push and pop keep the count
		if (push && !pop) begin
			next_st.count = st.count + CNT_W'(1);
		end else if (pop && !push) begin
			next_st.count = st.count - CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : hpc_pair_buffer

// [rtl/hpc_regs.sv]
// Host port control register two, status register and chain serializer
`timescale 1ns/10ps

module hpc_regs #(
	parameter int BUF_DEPTH = hpc_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire hpc_pkg::hpc_host_req_t host_req,
	output logic [hpc_pkg::BYTE_W-1:0] host_rdata,
	output logic host_ack,
	output logic host_interrupt_n,
	input wire hpc_pkg::hpc_cfg_status_t cfg_status,
	input wire logic [hpc_pkg::BYTE_W-1:0] rb_data,
	input wire logic user_interrupt_n,
	input wire logic program_n,
	input wire logic init_status_pin,
	input wire logic done_pin,
	input wire logic bitstream_user_mode,
	output logic chain_serial_out,
	output logic chain_serial_valid,
	output logic user_mode_active,
	output hpc_pkg::hpc_ctrl_t ctrl_out
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	generate
		if (BUF_DEPTH != 2) begin : g_bad_depth
			$error("hpc_regs serves a two-entry buffer only");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Address match for one request
	function automatic logic addr_hit(input hpc_pkg::hpc_host_req_t req,
		input logic [hpc_pkg::ADDR_W-1:0] addr);
		addr_hit = (req.addr == addr);
	endfunction : addr_hit

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	hpc_pkg::hpc_state_t st; // Registered state
	hpc_pkg::hpc_state_t next_st; // Next state
	logic buf_in_valid; // Byte offered to buffer
	logic buf_in_ready; // Buffer has room
	logic buf_out_valid; // Byte waiting for serializer
	logic buf_out_ready; // Serializer idle
	logic [hpc_pkg::BYTE_W-1:0] buf_out_data; // Byte at buffer head
	logic ser_busy; // Serializer shifting
	logic take_rd; // Read request accepted
	logic take_wr; // Write request accepted
	logic cfg_src; // Config data interrupt source
	logic err_src; // Stream error interrupt source
	logic usr_src; // User logic interrupt source
	logic cfg_req; // Config side can take a byte
	logic rb_req; // Readback byte waiting
	logic [hpc_pkg::BYTE_W-1:0] status_byte; // Live status value
	logic [hpc_pkg::BYTE_W-1:0] ctrl_byte; // Control readback value

	// ----------------------------------------------------------------
	// Outputs straight from state
	// ----------------------------------------------------------------
	assign host_rdata = st.rdata;
	assign host_ack = st.ack;
	assign host_interrupt_n = st.int_n;
	assign chain_serial_out = st.ser_out;
	assign chain_serial_valid = st.ser_valid;
	assign user_mode_active = st.user_mode_active;
	assign ctrl_out = st.ctrl;

	// ----------------------------------------------------------------
	// Data path buffer
	// ----------------------------------------------------------------
	// The serializer pulls a byte only while idle, so no byte is
	// overwritten mid-shift; a full buffer stalls the write sequencer
	// in the push state rather than losing the byte.
	// Busy while bits remain to shift
	assign ser_busy = (st.ser_cnt != '0);
	// Pull from the buffer only between bytes
	assign buf_out_ready = ~ser_busy;
	// Offer the latched byte while in the push state
	assign buf_in_valid = (st.wr_state == hpc_pkg::WR_PUSH);

	hpc_pair_buffer #(
		.WIDTH(hpc_pkg::BYTE_W),
		.DEPTH(BUF_DEPTH)
	) u_buffer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(st.wr_byte),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// ----------------------------------------------------------------
	// Request decode and interrupt sources
	// ----------------------------------------------------------------
	// Requests taken only while no write is in flight
	assign take_rd = host_req.rd & ~host_req.wr & (st.wr_state == hpc_pkg::WR_IDLE);
	assign take_wr = host_req.wr & ~host_req.rd & (st.wr_state == hpc_pkg::WR_IDLE);
	assign cfg_req = cfg_status.cfg_mode & cfg_status.cfg_byte_req;
	assign rb_req = cfg_status.readback_mode & cfg_status.rb_byte_avail;

	assign cfg_src = st.ctrl.cfg_data_irq_enable & st.ctrl.chain_output_enable & st.data_ready;
	assign err_src = st.ctrl.stream_error_irq_enable & cfg_status.cfg_mode
		& (st.err_flags != hpc_pkg::ERR_NONE);
	assign usr_src = st.ctrl.user_irq_enable & ~user_interrupt_n;

	// Status and control readback values
	always_comb begin
		status_byte = '0;
		status_byte[hpc_pkg::STAT_DATA_READY_BIT] = st.data_ready;
		status_byte[hpc_pkg::STAT_IRQ_PEND_BIT] = st.irq_pending;
		status_byte[hpc_pkg::STAT_ERR_MSB:hpc_pkg::STAT_ERR_LSB] = st.err_flags;
		status_byte[hpc_pkg::STAT_INIT_BIT] = init_status_pin;
		status_byte[hpc_pkg::STAT_DONE_BIT] = done_pin;
		ctrl_byte = {2'h0, st.ctrl};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// Acknowledge is a one-cycle pulse unless set below
		next_st.ack = 1'b0;
		next_st.prev_cfg_req = cfg_req;
		next_st.prev_rb_req = rb_req;
		next_st.prev_done = done_pin;

		// Register reads answer one cycle later
		if (take_rd) begin
			next_st.ack = 1'b1;
			if (addr_hit(host_req, hpc_pkg::ADDR_CTRL_TWO)) begin
				next_st.rdata = ctrl_byte;
			end else if (addr_hit(host_req, hpc_pkg::ADDR_STATUS)) begin
				next_st.rdata = status_byte;
			end else if (addr_hit(host_req, hpc_pkg::ADDR_CFG_DATA)) begin
				next_st.rdata = rb_data;
			end else begin
				// Unmapped reads return zero
				next_st.rdata = '0;
			end
		end

		// Write sequencer
		unique case (st.wr_state)
			hpc_pkg::WR_IDLE: begin
				if (take_wr) begin
					if (addr_hit(host_req, hpc_pkg::ADDR_CTRL_TWO)) begin
						next_st.ctrl = host_req.wdata[hpc_pkg::CTRL_FIELD_W-1:0];
						next_st.ack = 1'b1;
					end else if (addr_hit(host_req, hpc_pkg::ADDR_CFG_DATA)
						&& st.ctrl.chain_output_enable) begin
						// Byte queued toward the chain
						next_st.wr_byte = host_req.wdata;
						next_st.wr_state = hpc_pkg::WR_PUSH;
					end else begin
						next_st.ack = 1'b1;
					end
				end
			end
			hpc_pkg::WR_PUSH: begin
				if (buf_in_ready) begin
					if (st.ctrl.bus_hold_enable) begin
						next_st.wr_state = hpc_pkg::WR_HOLD;
					end else begin
						next_st.ack = 1'b1;
						next_st.wr_state = hpc_pkg::WR_IDLE;
					end
				end
			end
			hpc_pkg::WR_HOLD: begin
				// Ack after byte serialized
				// Byte gone once buffer empty and no bit left
				if (!buf_out_valid && !ser_busy) begin
					next_st.ack = 1'b1;
					next_st.wr_state = hpc_pkg::WR_IDLE;
				end
			end
			default: begin
				next_st.wr_state = hpc_pkg::WR_IDLE;
			end
		endcase

		next_st.ser_valid = 1'b0;
		if (ser_busy) begin
			next_st.ser_out = st.ser_shift[hpc_pkg::BYTE_W-1];
			next_st.ser_valid = 1'b1;
			next_st.ser_shift = {st.ser_shift[hpc_pkg::BYTE_W-2:0], 1'b0};
			next_st.ser_cnt = st.ser_cnt - hpc_pkg::SER_CNT_W'(1);
		end else if (buf_out_valid) begin
			next_st.ser_shift = buf_out_data;
			next_st.ser_cnt = hpc_pkg::SER_BITS;
		end

		if ((take_rd || take_wr) && addr_hit(host_req, hpc_pkg::ADDR_CFG_DATA)) begin
			next_st.data_ready = 1'b0;
		end
		if ((cfg_req && !st.prev_cfg_req) || (rb_req && !st.prev_rb_req)) begin
			next_st.data_ready = 1'b1;
		end

		if (take_rd && addr_hit(host_req, hpc_pkg::ADDR_STATUS)) begin
			next_st.irq_pending = 1'b0;
		end
		if (cfg_src || err_src || usr_src) begin
			next_st.irq_pending = 1'b1;
		end

		if (!program_n) begin
			next_st.err_flags = hpc_pkg::ERR_NONE;
		end
		if (cfg_status.stream_error_valid) begin
			next_st.err_flags = cfg_status.stream_error_code;
		end

		next_st.int_n = ~(cfg_src | err_src | usr_src);

		// Register bit counts only at the rising done edge;
		// setting it later leaves the port in its current mode.
		// User mode after done
		if (!done_pin) begin
			next_st.user_mode_active = 1'b0;
		end else if (!st.prev_done) begin
			next_st.user_mode_active = st.ctrl.user_mode_enable | bitstream_user_mode;
		end else if (bitstream_user_mode) begin
			next_st.user_mode_active = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Port idle, interrupt pin released
			// Control bits reset to zero
			st <= '0;
			st.ctrl <= hpc_pkg::CTRL_RESET[hpc_pkg::CTRL_FIELD_W-1:0];
			st.wr_state <= hpc_pkg::WR_IDLE;
			st.int_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule : hpc_regs

// [verification/hpc_regs_assertions.sv]
// Concurrent checks on the host port control and status register ports
`timescale 1ns/10ps
module hpc_regs_checker (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire hpc_pkg::hpc_host_req_t host_req,
	input wire logic [hpc_pkg::BYTE_W-1:0] host_rdata,
	input wire logic host_ack,
	input wire logic host_interrupt_n,
	input wire logic user_interrupt_n,
	input wire logic init_status_pin,
	input wire logic done_pin,
	input wire logic chain_serial_valid,
	input wire hpc_pkg::hpc_ctrl_t ctrl_out
);
	// ----------------------------------------
	// Clocking and sequences
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Config data write, no read
	sequence s_cfg_wr;
		host_req.wr && !host_req.rd && host_req.addr == hpc_pkg::ADDR_CFG_DATA;
	endsequence
	// Status read request
	sequence s_stat_rd;
		host_req.rd && !host_req.wr && host_req.addr == hpc_pkg::ADDR_STATUS;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_reset_values: assert property (
		$past(sys_rst) |-> ctrl_out == '0 && host_interrupt_n && !host_ack)
		else $error("outputs not at reset values");
	a_user_forward: assert property (
		ctrl_out.user_irq_enable && !user_interrupt_n |=> !host_interrupt_n)
		else $error("user request not forwarded");
	a_idle_high: assert property (
		!ctrl_out.cfg_data_irq_enable && !ctrl_out.stream_error_irq_enable
		&& !(ctrl_out.user_irq_enable && !user_interrupt_n) |=> host_interrupt_n)
		else $error("interrupt without enabled source");
	a_pin_mirror: assert property (
		s_stat_rd |=> host_ack && host_rdata[7] == $past(done_pin)
		&& host_rdata[6] == $past(init_status_pin))
		else $error("status pins not mirrored");
	a_status_ro: assert property (
		host_req.wr && !host_req.rd && host_req.addr == hpc_pkg::ADDR_STATUS
		|=> $stable(ctrl_out) && host_ack)
		else $error("status write had an effect");
	a_hold_wait: assert property (
		s_cfg_wr ##0 (ctrl_out.chain_output_enable && ctrl_out.bus_hold_enable)
		|=> !host_ack [*8])
		else $error("held write acked early");
	a_no_hold_ack: assert property (
		s_cfg_wr ##0 !ctrl_out.chain_output_enable |=> host_ack)
		else $error("write not acked at once");
	a_byte_length: assert property (
		$rose(chain_serial_valid) |-> chain_serial_valid [*8] ##1 !chain_serial_valid)
		else $error("serial byte too short");
	a_no_shift: assert property (
		!ctrl_out.chain_output_enable && !chain_serial_valid |=> !chain_serial_valid)
		else $error("shifting without chain enable");
endmodule : hpc_regs_checker

bind hpc_regs hpc_regs_checker chk_i (.mclk, .sys_rst, .host_req, .host_rdata, .host_ack,
	.host_interrupt_n, .user_interrupt_n, .init_status_pin, .done_pin, .chain_serial_valid,
	.ctrl_out);

// [verification/hpc_host_model.sv]
// Host processor model issuing single byte register cycles
`timescale 1ns/10ps
module hpc_host_model (
	input wire logic mclk,
	input wire logic host_ack,
	input wire logic [hpc_pkg::BYTE_W-1:0] host_rdata,
	output hpc_pkg::hpc_host_req_t host_req
);
	// Bus idle from time zero
	initial begin
		host_req = '0;
	end
	// One cycle; returns data and cycles to ack
	task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q, output int lat);
		@(posedge mclk);
		host_req <= {rd, !rd, a, d};
		@(posedge mclk);
		host_req <= '0;
		lat = 1;
		@(posedge mclk);
		// Bounded wait for ack
		while (!host_ack && lat < 40) begin
			@(posedge mclk);
			lat++;
		end
		q = host_rdata;
	endtask : access
endmodule : hpc_host_model

// [verification/tb_top.sv]
// Self-checking bench of the host port control and status registers
`timescale 1ns/10ps
module tb_top;
	logic mclk;
	logic sys_rst;
	hpc_pkg::hpc_host_req_t host_req;
	logic [7:0] host_rdata;
	logic host_ack;
	logic host_interrupt_n;
	hpc_pkg::hpc_cfg_status_t cfg_status;
	logic [7:0] rb_data;
	logic user_interrupt_n;
	logic program_n;
	logic init_status_pin;
	logic done_pin;
	logic bitstream_user_mode;
	logic chain_serial_out;
	logic chain_serial_valid;
	logic user_mode_active;
	hpc_pkg::hpc_ctrl_t ctrl_out;
	int errors;
	int comparisons;
	int cycles;
	int lat;
	logic [7:0] q;
	logic [7:0] d;
	int ctrl_m;
	int dr_m;
	int pend_m;
	int err_m;
	logic ser_q[$];
	logic exp_q[$];
	// ----------------------------------------
	// Design, host model, clock
	// ----------------------------------------
	hpc_regs hpc_regs_i (.mclk, .sys_rst, .host_req, .host_rdata, .host_ack, .host_interrupt_n,
		.cfg_status, .rb_data, .user_interrupt_n, .program_n, .init_status_pin, .done_pin,
		.bitstream_user_mode, .chain_serial_out, .chain_serial_valid, .user_mode_active,
		.ctrl_out);
	hpc_host_model host_i (.mclk, .host_ack, .host_rdata, .host_req);
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	// Serial bit capture, hang guard
	always @(posedge mclk) begin
		if (chain_serial_valid === 1'b1) ser_q.push_back(chain_serial_out);
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("BAD %0t timeout", $time);
			finish_test();
		end
	end
	// ----------------------------------------
	// Model, compare and bus helpers
	// ----------------------------------------
	function automatic logic [7:0] st_m();
		return {done_pin, init_status_pin, 1'b0, err_m[1:0], pend_m[0], dr_m[0], 1'b0};
	endfunction : st_m
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk8
	// A missing acknowledge counts as a mismatch
	task automatic ack_ok();
		if (lat >= 40) begin
			errors++;
			$display("BAD %0t no acknowledge", $time);
		end
	endtask : ack_ok
	task automatic rd(input logic [4:0] a);
		host_i.access(1'b1, a, 8'h00, q, lat);
		ack_ok();
	endtask : rd
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		host_i.access(1'b0, a, v, q, lat);
		ack_ok();
		if (a == hpc_pkg::ADDR_CTRL_TWO) ctrl_m = v & 8'h3f;
		if (a == hpc_pkg::ADDR_CFG_DATA) dr_m = 0;
	endtask : wr
	// Status read against model, pending cleared
	task automatic rs();
		rd(hpc_pkg::ADDR_STATUS);
		chk8(q, st_m());
		pend_m = 0;
	endtask : rs
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_n
	task automatic finish_test();
		if (errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		sys_rst = 1;
		cfg_status = '0;
		rb_data = 8'h00;
		user_interrupt_n = 1;
		program_n = 1;
		init_status_pin = 0;
		done_pin = 0;
		bitstream_user_mode = 0;
		ctrl_m = 0;
		dr_m = 0;
		pend_m = 0;
		err_m = 0;
		d = $urandom(32'ha765);
		wait_n(5);
		sys_rst <= 0;
		{done_pin, init_status_pin} <= 2'($urandom);
		rd(hpc_pkg::ADDR_CTRL_TWO);
		chk8(q, 8'h00);
		rs();
		// Random control bytes, port and read back
		repeat (4) begin
			wr(hpc_pkg::ADDR_CTRL_TWO, 8'($urandom));
			chk8(8'(ctrl_out), ctrl_m[7:0]);
			rd(hpc_pkg::ADDR_CTRL_TWO);
			chk8(q, ctrl_m[7:0]);
		end
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h00);
		wr(hpc_pkg::ADDR_STATUS, 8'hff);
		rs();
		rd(5'h1f);
		chk8(q, 8'h00);
		// Every error code, then program clear
		cfg_status.cfg_mode <= 1;
		for (int c = 1; c < 4; c++) begin
			cfg_status.stream_error_code <= 2'(c);
			cfg_status.stream_error_valid <= 1;
			wait_n(1);
			cfg_status.stream_error_valid <= 0;
			err_m = c;
			rs();
		end
		program_n <= 0;
		wait_n(2);
		program_n <= 1;
		err_m = 0;
		rs();
		// Error interrupt in configuration
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h02);
		cfg_status.stream_error_code <= 2'h1;
		cfg_status.stream_error_valid <= 1;
		wait_n(1);
		cfg_status.stream_error_valid <= 0;
		err_m = 1;
		wait_n(2);
		chk8(host_interrupt_n, 8'h00);
		pend_m = 1;
		rs();
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h00);
		rd(hpc_pkg::ADDR_STATUS);
		// User request held until serviced
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h04);
		user_interrupt_n <= 0;
		wait_n(3);
		chk8(host_interrupt_n, 8'h00);
		pend_m = 1;
		rs();
		pend_m = 1;
		rs();
		pend_m = 1;
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h00);
		wait_n(2);
		chk8(host_interrupt_n, 8'h01);
		user_interrupt_n <= 1;
		wait_n(2);
		rs();
		rs();
		// Byte request raises data ready and interrupt
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h09);
		cfg_status.cfg_byte_req <= 1;
		wait_n(3);
		dr_m = 1;
		chk8(host_interrupt_n, 8'h00);
		pend_m = 1;
		rs();
		pend_m = 1;
		// Ack latency per mode; held: push, load, eight bits, ack
		for (int m = 0; m < 3; m++) begin
			wr(hpc_pkg::ADDR_CTRL_TWO, (m == 0) ? 8'h00 : ((m == 1) ? 8'h08 : 8'h18));
			d = 8'($urandom);
			wr(hpc_pkg::ADDR_CFG_DATA, d);
			chk8(8'(lat), (m == 0) ? 8'd1 : ((m == 1) ? 8'd2 : 8'(hpc_pkg::SER_BITS) + 8'd4));
			if (m > 0) begin
				for (int b = 7; b >= 0; b--) begin
					exp_q.push_back(d[b]);
				end
			end
			wait_n(12);
		end
		rs();
		chk8(8'(ser_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) chk8(ser_q[i], exp_q[i]);
		// Readback byte waiting
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h00);
		cfg_status <= '0;
		done_pin <= 0;
		wait_n(1);
		cfg_status.readback_mode <= 1;
		cfg_status.rb_byte_avail <= 1;
		rb_data <= 8'($urandom);
		wait_n(3);
		dr_m = 1;
		rs();
		rd(hpc_pkg::ADDR_CFG_DATA);
		chk8(q, rb_data);
		dr_m = 0;
		rs();
		// Error enable has no effect outside configuration
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h02);
		wait_n(3);
		chk8(host_interrupt_n, 8'h01);
		// User mode set before done, then by bit stream
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h20);
		done_pin <= 1;
		wait_n(3);
		chk8(user_mode_active, 8'h01);
		done_pin <= 0;
		wait_n(3);
		chk8(user_mode_active, 8'h00);
		wr(hpc_pkg::ADDR_CTRL_TWO, 8'h00);
		bitstream_user_mode <= 1;
		done_pin <= 1;
		wait_n(3);
		chk8(user_mode_active, 8'h01);
		finish_test();
	end
endmodule : tb_top
